/* dv/tb_voice_codec_gain_tone_control.sv */
// bench: both codec control ends on one link, driven over apb
`timescale 1ns/1ps
module tb_voice_codec_gain_tone_control;
	logic               sys_clk;
	logic               rst;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic        [7:0]  paddr;
	logic        [31:0] pwdata;
	logic        [31:0] prdata;
	logic               pready;
	logic               pslverr;
	logic        [6:0]  tx_gain_half_db;
	logic               tx_extended;
	logic               tx_code_valid;
	logic        [6:0]  mic_atten_db;
	logic signed [4:0]  rx_gain_db;
	logic               rx_code_valid;
	logic signed [4:0]  tone_gain_db;
	logic signed [5:0]  sidetone_gain_db;
	logic               sidetone_muted;
	logic signed [5:0]  volume_gain_db;
	logic               earphone_muted;
	logic signed [15:0] rx_sample;
	logic               rx_sample_valid;
	logic        [3:0]  frame_gain_code;
	logic signed [4:0]  tone_sum;
	logic               buzzer_control_output;
	logic        [31:0] q;
	logic        [7:0]  pw [3];
	int                 fails;
	int                 n_checks;
	int                 e;
	vcg_link_if link ();
	vcg_device vcg_device_inst (.sys_clk(sys_clk), .rst(rst), .link(link.dev),
		.tx_gain_half_db(tx_gain_half_db), .tx_extended(tx_extended),
		.tx_code_valid(tx_code_valid), .mic_atten_db(mic_atten_db), .rx_gain_db(rx_gain_db),
		.rx_code_valid(rx_code_valid), .tone_gain_db(tone_gain_db),
		.sidetone_gain_db(sidetone_gain_db), .sidetone_muted(sidetone_muted),
		.volume_gain_db(volume_gain_db), .earphone_muted(earphone_muted),
		.rx_sample(rx_sample), .rx_sample_valid(rx_sample_valid),
		.frame_gain_code(frame_gain_code), .tone_sum(tone_sum),
		.buzzer_control_output(buzzer_control_output));
	vcg_host vcg_host_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.host));
	vcg_link_props vcg_link_props_inst (.sys_clk(sys_clk), .rst(rst), .reg_wr(link.reg_wr),
		.reg_rd(link.reg_rd), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
		.sample_frame_sync(link.sample_frame_sync), .bit_strobe(link.bit_strobe),
		.pcm_data(link.pcm_data));
	task automatic results();
		if (fails == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [15:0] x, input logic [15:0] g);
		n_checks++;
		if (g !== x) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", s, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			results();
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// busy is polled after every command; the extra edges let decoded outputs land
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, vcg_pkg::APB_STATUS, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 200);
		if (n >= 200) begin
			fails++;
			results();
		end
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, vcg_pkg::APB_CMD, {16'h0000, a, d});
		wait_idle();
	endtask
	task automatic dev_rd(input logic [7:0] a);
		apb(1'b1, vcg_pkg::APB_CMD, {15'h0000, 1'b1, a, 8'h00});
		wait_idle();
	endtask
	// the first word after a sample write may still be the old one
	task automatic wait_word();
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
			end while (rx_sample_valid !== 1'b1 && n < 8000);
			if (n >= 8000) begin
				fails++;
				results();
			end
		end
		@(posedge sys_clk);
	endtask
	// resolution is 125/16 Hz shifted left by the setting
	function automatic logic [7:0] word(input int f, input int r);
		return 8'(((f * 32) / (125 << r) + 1) / 2);
	endfunction
	initial begin
		sys_clk = 1'b0;
		forever begin
			#20 sys_clk = ~sys_clk;
		end
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fails = 0;
		n_checks = 0;
		pw = '{8'hC8, 8'h40, 8'h88};
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("tx reset", 16'd47, tx_gain_half_db);
		chk("rx reset", -16'sd4, rx_gain_db);
		chk("sidetone reset", -16'sd12, sidetone_gain_db);
		chk("volume reset", 16'd0, volume_gain_db);
		dev_rd(vcg_pkg::ADDR_TX_GAIN);
		chk("tx reg reset", 16'h0B, q[15:8]);
		for (int c = 0; c < 16; c++) begin
			dev_wr(vcg_pkg::ADDR_TX_GAIN, 8'(c));
			e = c <= 5 ? 83 - 4 * c : (c >= 8 && c <= 13 ? 59 - 4 * (c - 8) : 0);
			chk("tx gain", 16'(e), tx_gain_half_db);
			chk("tx extended", 16'(c <= 5), tx_extended);
			chk("tx valid", 16'(e != 0), tx_code_valid);
		end
		for (int m = 0; m < 2; m++) begin
			dev_wr(vcg_pkg::ADDR_AUX, 8'(m));
			for (int c = 0; c < 16; c++) begin
				dev_wr(vcg_pkg::ADDR_RX_GAIN, 8'(c));
				chk("rx gain", 16'(c <= 12 ? 6 - c : 0), rx_gain_db);
				chk("rx valid", 16'(c <= 12), rx_code_valid);
				e = (m == 1 && c != 15) ? 12 - 6 * (c / 3) : 0;
				chk("tone gain", 16'(e), tone_gain_db);
			end
		end
		for (int i = 0; i < 10; i++) begin
			dev_wr(vcg_pkg::ADDR_ST_VOL, {1'b0, 3'(i % 7), 4'(i)});
			chk("sidetone", 16'(-12 - 2 * (i % 7)), sidetone_gain_db);
			chk("volume", 16'(-2 * i), volume_gain_db);
		end
		foreach (pw[i]) begin
			dev_wr(vcg_pkg::ADDR_POWER, pw[i]);
			chk("mic atten", pw[i][6] ? 16'd80 : 16'd0, mic_atten_db);
			chk("sidetone mute", 16'(pw[i][7]), sidetone_muted);
			chk("ear mute", 16'(pw[i][3]), earphone_muted);
		end
		dev_wr(vcg_pkg::ADDR_TONE_HI, 8'hA7);
		dev_wr(vcg_pkg::ADDR_TONE_LO, 8'h3C);
		dev_rd(vcg_pkg::ADDR_TONE_HI);
		chk("high tone reg", 16'hA7, q[15:8]);
		dev_rd(vcg_pkg::ADDR_TONE_LO);
		chk("low tone reg", 16'h3C, q[15:8]);
		dev_rd(8'h07);
		chk("unmapped dev reg", 16'h00, q[15:8]);
		for (int r = 0; r < 3; r++) begin
			dev_wr(vcg_pkg::ADDR_AUX, 8'(r << 2));
			dev_rd(vcg_pkg::ADDR_AUX);
			chk("aux resolution", 16'(r << 2), q[15:8]);
		end
		apb(1'b1, 8'h14, 32'hFFFF_FFFF);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped apb", 16'h0000, q[15:0]);
		apb(1'b1, vcg_pkg::APB_TONES, {6'h00, 2'h0, 12'd1209, 12'd697});
		wait_idle();
		dev_rd(vcg_pkg::ADDR_TONE_HI);
		chk("high word", word(1209, 0), q[15:8]);
		dev_rd(vcg_pkg::ADDR_TONE_LO);
		chk("low word", word(697, 0), q[15:8]);
		apb(1'b1, vcg_pkg::APB_TONES, {6'h00, 2'h1, 12'd852, 12'd1336});
		wait_idle();
		dev_rd(vcg_pkg::ADDR_TONE_HI);
		chk("high word swap", word(1336, 1), q[15:8]);
		dev_rd(vcg_pkg::ADDR_TONE_LO);
		chk("low word swap", word(852, 1), q[15:8]);
		dev_wr(vcg_pkg::ADDR_AUX, 8'h00);
		apb(1'b1, vcg_pkg::APB_CONFIG, {27'h0, 4'h9, 1'b0});
		apb(1'b1, vcg_pkg::APB_SAMPLE, 32'h0000_00A5);
		wait_word();
		chk("companded word", 16'h00A5, rx_sample);
		// gain bits trail the word by four slots
		repeat (60) @(posedge sys_clk);
		chk("gain bits", 16'h9, frame_gain_code);
		chk("buzzer idle", 16'h0, buzzer_control_output);
		dev_wr(vcg_pkg::ADDR_TONE_LO, 8'h00);
		dev_wr(vcg_pkg::ADDR_AUX, 8'h01);
		wait_word();
		chk("high tone level", 16'd5, 16'(tone_sum < 0 ? -tone_sum : tone_sum));
		// whole pdm periods, so the density is exact whatever the accumulator held
		e = 0;
		repeat (180) begin
			@(posedge sys_clk);
			e += buzzer_control_output;
		end
		chk("buzzer density", 16'(tone_sum < 0 ? 40 : 140), 16'(e));
		dev_wr(vcg_pkg::ADDR_TONE_HI, 8'h00);
		dev_wr(vcg_pkg::ADDR_TONE_LO, 8'h3C);
		wait_word();
		chk("low tone level", 16'd4, 16'(tone_sum < 0 ? -tone_sum : tone_sum));
		dev_wr(vcg_pkg::ADDR_AUX, 8'h02);
		apb(1'b1, vcg_pkg::APB_CONFIG, {27'h0, 4'h0, 1'b1});
		apb(1'b1, vcg_pkg::APB_SAMPLE, 32'h0000_4321);
		wait_word();
		chk("linear word", 16'hC321, rx_sample);
		results();
	end
endmodule

/* dv/vcg_link_props.sv */
// checker for the register link and pcm framing between the two ends
`timescale 1ns/1ps
module vcg_link_props (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// register access
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_ack,
	// pcm framing
	input  wire logic       sample_frame_sync,
	input  wire logic       bit_strobe,
	input  wire logic       pcm_data
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [4:0]  slot;
	logic [11:0] gap;
	logic [12:0] fcyc;
	logic        seen;
	// gap and frame counters saturate so a stalled link cannot wrap round into a pass
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slot <= 5'h00;
		end else if (bit_strobe) begin
			slot <= sample_frame_sync ? 5'h01 : slot + 5'h01;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst || bit_strobe) begin
			gap <= 12'h000;
		end else if (gap != 12'hFFF) begin
			gap <= gap + 12'h001;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst || sample_frame_sync) begin
			fcyc <= 13'h0000;
		end else if (fcyc != 13'h1FFF) begin
			fcyc <= fcyc + 13'h0001;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			seen <= 1'b0;
		end else if (sample_frame_sync) begin
			seen <= 1'b1;
		end
	end
	a_ack_follows_req: assert property ((reg_wr || reg_rd) |=> reg_ack)
		else $error("register access not acknowledged next cycle");
	a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
		else $error("acknowledge without a request");
	a_unmapped_read_zero: assert property (reg_rd && reg_addr >= 8'h07 |=> reg_rdata == 8'h00)
		else $error("unmapped register read not zero");
	a_sync_on_strobe: assert property (sample_frame_sync |-> bit_strobe)
		else $error("frame sync without slot strobe");
	a_strobe_gap_min: assert property (bit_strobe |=> !bit_strobe [*8])
		else $error("slot strobes too close");
	a_strobe_spacing: assert property (bit_strobe && slot != 5'h00 && !sample_frame_sync
		|-> gap == 12'(vcg_pkg::BIT_CYC - 1))
		else $error("slot strobe spacing wrong");
	a_slot_limit: assert property (bit_strobe && !sample_frame_sync
		|-> slot >= 5'h01 && slot <= 5'h0F)
		else $error("more than sixteen slots in a frame");
	a_frame_full: assert property (sample_frame_sync && seen |-> slot == 5'h10)
		else $error("frame ended without sixteen slots");
	a_frame_period: assert property (sample_frame_sync && seen
		|-> fcyc == 13'(vcg_pkg::FRAME_CYC - 1))
		else $error("frame sync period wrong");
endmodule

/* verilog/vcg_device.sv */
// codec control device: registers, gain decode, pcm receive, tone and buzzer
`timescale 1ns/1ps
module vcg_device (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// link
	vcg_link_if.dev                link,
	// transmit path
	output logic       [6:0]       tx_gain_half_db,
	output logic                   tx_extended,
	output logic                   tx_code_valid,
	output logic       [6:0]       mic_atten_db,
	// receive path
	output logic signed [4:0]      rx_gain_db,
	output logic                   rx_code_valid,
	output logic signed [4:0]      tone_gain_db,
	output logic signed [5:0]      sidetone_gain_db,
	output logic                   sidetone_muted,
	output logic signed [5:0]      volume_gain_db,
	output logic                   earphone_muted,
	// received samples
	output logic signed [15:0]     rx_sample,
	output logic                   rx_sample_valid,
	output logic       [3:0]       frame_gain_code,
	// tone and buzzer
	output logic signed [4:0]      tone_sum,
	output logic                   buzzer_control_output
);
	logic [7:0] regs [0:vcg_pkg::NUM_REGS-1];
	logic [7:0] power_control;
	logic [3:0] transmit_gain_code;
	logic [3:0] receive_gain_code;
	logic [2:0] sidetone_gain_code;
	logic [3:0] earphone_volume_code;
	logic [7:0] auxiliary_control;
	logic       tone_mode;
	logic       linear_mode;
	logic [1:0] res_shift;

	assign power_control        = regs[vcg_pkg::ADDR_POWER[2:0]];
	assign transmit_gain_code   = regs[vcg_pkg::ADDR_TX_GAIN[2:0]][3:0];
	assign receive_gain_code    = regs[vcg_pkg::ADDR_RX_GAIN[2:0]][3:0];
	assign sidetone_gain_code   = regs[vcg_pkg::ADDR_ST_VOL[2:0]][vcg_pkg::ST_LSB +: 3];
	assign earphone_volume_code = regs[vcg_pkg::ADDR_ST_VOL[2:0]][3:0];
	assign auxiliary_control    = regs[vcg_pkg::ADDR_AUX[2:0]];
	assign tone_mode            = auxiliary_control[vcg_pkg::BIT_TONE_MODE];
	assign linear_mode          = auxiliary_control[vcg_pkg::BIT_LINEAR];

	// register file; tone words live at 04 and 05
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			regs[0] <= vcg_pkg::RST_POWER;
			regs[1] <= vcg_pkg::RST_TX_GAIN;
			regs[2] <= vcg_pkg::RST_RX_GAIN;
			regs[3] <= vcg_pkg::RST_ST_VOL;
			regs[4] <= vcg_pkg::RST_TONE;
			regs[5] <= vcg_pkg::RST_TONE;
			regs[6] <= vcg_pkg::RST_AUX;
		end else if (link.reg_wr && link.reg_addr < 8'(vcg_pkg::NUM_REGS)) begin
			regs[link.reg_addr[2:0]] <= link.reg_wdata;
		end
	end

	// every access is answered one cycle later; unmapped reads give zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link.reg_ack   <= 1'b0;
			link.reg_rdata <= 8'h00;
		end else begin
			link.reg_ack <= link.reg_wr || link.reg_rd;
			if (link.reg_rd)
				link.reg_rdata <= (link.reg_addr < 8'(vcg_pkg::NUM_REGS)) ?
					regs[link.reg_addr[2:0]] : 8'h00;
		end
	end

	// transmit gain decode
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_gain_half_db <= 7'h00;
			tx_extended     <= 1'b0;
			tx_code_valid   <= 1'b0;
			mic_atten_db    <= 7'h00;
		end else begin
			tx_extended   <= transmit_gain_code <= vcg_pkg::TX_EXT_LAST;
			tx_code_valid <= transmit_gain_code <= vcg_pkg::TX_EXT_LAST ||
				(transmit_gain_code >= vcg_pkg::TX_NORM_FIRST &&
				transmit_gain_code <= vcg_pkg::TX_NORM_LAST);
			if (transmit_gain_code <= vcg_pkg::TX_EXT_LAST)
				tx_gain_half_db <= vcg_pkg::TX_EXT_TOP_X2 - {1'b0, transmit_gain_code, 2'b00};
			else if (transmit_gain_code >= vcg_pkg::TX_NORM_FIRST &&
				transmit_gain_code <= vcg_pkg::TX_NORM_LAST)
				tx_gain_half_db <= vcg_pkg::TX_NORM_TOP_X2 -
					{2'b00, transmit_gain_code[2:0], 2'b00};
			else
				tx_gain_half_db <= 7'h00;
			mic_atten_db <= power_control[vcg_pkg::BIT_MIC_MUTE] ?
				vcg_pkg::MIC_MUTE_DB : 7'h00;
		end
	end

	// receive, tone, sidetone and volume decode
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_gain_db       <= 5'sh00;
			rx_code_valid    <= 1'b0;
			tone_gain_db     <= 5'sh00;
			sidetone_gain_db <= 6'sh00;
			sidetone_muted   <= 1'b0;
			volume_gain_db   <= 6'sh00;
			earphone_muted   <= 1'b0;
		end else begin
			rx_code_valid <= receive_gain_code <= vcg_pkg::RX_LAST;
			rx_gain_db    <= (receive_gain_code <= vcg_pkg::RX_LAST) ?
				5'sh06 - $signed({1'b0, receive_gain_code}) : 5'sh00;
			if (!tone_mode)
				tone_gain_db <= 5'sh00;
			else if (receive_gain_code < 4'h3)
				tone_gain_db <= 5'sh0C;
			else if (receive_gain_code < 4'h6)
				tone_gain_db <= 5'sh06;
			else if (receive_gain_code < 4'h9)
				tone_gain_db <= 5'sh00;
			else if (receive_gain_code < 4'hC)
				tone_gain_db <= -5'sh06;
			else if (receive_gain_code < 4'hF)
				tone_gain_db <= -5'sh0C;
			else
				tone_gain_db <= 5'sh00;
			sidetone_gain_db <= -6'sh0C - $signed({2'b00, sidetone_gain_code, 1'b0});
			sidetone_muted   <= power_control[vcg_pkg::BIT_ST_MUTE];
			volume_gain_db   <= -$signed({1'b0, earphone_volume_code, 1'b0});
			earphone_muted   <= power_control[vcg_pkg::BIT_EAR_MUTE];
		end
	end

	// pcm receive: slot counter starts at the frame sync, bits taken on strobes
	logic [4:0]  slot;
	logic [14:0] shift;
	logic        in_frame;
	logic [4:0]  word_bits;
	logic [4:0]  next_slot;

	assign word_bits = linear_mode ? vcg_pkg::LIN_BITS : vcg_pkg::COMP_BITS;
	assign next_slot = link.sample_frame_sync ? 5'h01 : slot + 5'h01;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slot            <= 5'h00;
			in_frame        <= 1'b0;
			shift           <= 15'h0000;
			rx_sample       <= 16'sh0000;
			rx_sample_valid <= 1'b0;
			frame_gain_code <= 4'h0;
		end else begin
			rx_sample_valid <= 1'b0;
			if (link.bit_strobe && (in_frame || link.sample_frame_sync)) begin
				slot     <= next_slot;
				in_frame <= next_slot < vcg_pkg::SLOTS;
				if (next_slot <= word_bits)
					shift <= {shift[13:0], link.pcm_data};
				if (next_slot == word_bits) begin
					rx_sample_valid <= 1'b1;
					if (linear_mode)
						rx_sample <= {shift[13], shift[13:0], link.pcm_data};
					else
						rx_sample <= {8'h00, shift[6:0], link.pcm_data};
				end
				// gain bits only after the companded word; slot 16 carries nothing
				if (!linear_mode && next_slot > word_bits &&
					next_slot <= word_bits + vcg_pkg::FGAIN_BITS)
					frame_gain_code <= {frame_gain_code[2:0], link.pcm_data};
			end
		end
	end

	// tone generator runs at the frame rate, square waves stand in for the sine table
	logic [9:0]  phase_hi;
	logic [9:0]  phase_lo;
	logic [9:0]  inc_hi;
	logic [9:0]  inc_lo;
	logic        tick;

	assign res_shift = auxiliary_control[vcg_pkg::RES_LSB +: 2];
	assign inc_hi = 10'({2'b00, regs[vcg_pkg::ADDR_TONE_HI[2:0]]} << res_shift);
	assign inc_lo = 10'({2'b00, regs[vcg_pkg::ADDR_TONE_LO[2:0]]} << res_shift);
	assign tick   = link.sample_frame_sync;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			phase_hi <= 10'h000;
			phase_lo <= 10'h000;
			tone_sum <= 5'sh00;
		end else if (tick) begin
			phase_hi <= phase_hi + inc_hi;
			phase_lo <= phase_lo + inc_lo;
			tone_sum <= (inc_hi == 10'h000 ? 5'sh00 : phase_hi[9] ?
				-$signed({1'b0, vcg_pkg::TONE_HI_AMP}) : $signed({1'b0, vcg_pkg::TONE_HI_AMP}))
				+ (inc_lo == 10'h000 ? 5'sh00 : phase_lo[9] ?
				-$signed({1'b0, vcg_pkg::TONE_LO_AMP}) : $signed({1'b0, vcg_pkg::TONE_LO_AMP}));
		end
	end

	// first order pdm of the summed tones; idle buzzer stays low outside tone mode
	logic [5:0] pdm_acc;
	logic [5:0] pdm_sum;

	assign pdm_sum = pdm_acc + 6'(tone_sum + 5'sh09);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pdm_acc               <= 6'h00;
			buzzer_control_output <= 1'b0;
		end else if (!tone_mode) begin
			pdm_acc               <= 6'h00;
			buzzer_control_output <= 1'b0;
		end else begin
			buzzer_control_output <= pdm_sum >= 6'h12;
			pdm_acc <= (pdm_sum >= 6'h12) ? pdm_sum - 6'h12 : pdm_sum;
		end
	end
endmodule

/* verilog/vcg_host.sv */
// host end: apb registers, device register access, tone words, pcm framing
`timescale 1ns/1ps
module vcg_host (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// link
	vcg_link_if.host         link
);
	typedef enum {S_IDLE, S_CMD, S_HI, S_LO} vcg_hstate_t;
	vcg_hstate_t state;
	logic        issued;
	logic        busy;
	logic [16:0] cmd;
	logic [7:0]  read_data;
	logic [15:0] sample_hold;
	logic [4:0]  config_bits;
	logic [7:0]  word_hi;
	logic [7:0]  word_lo;
	logic        apb_wr;
	logic [1:0]  tone_res;

	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign apb_wr  = psel && penable && pwrite;
	assign busy    = state != S_IDLE;
	assign tone_res = pwdata[vcg_pkg::TONES_RES_LSB +: 2];

	// word = round(freq / res), res = 7.8125 * 2^shift, computed as freq*128/(1000<<shift)
	function automatic logic [7:0] tone_word(input logic [11:0] freq, input logic [1:0] sh);
		logic [31:0] num;
		logic [31:0] den;
		logic [31:0] q;
		num = 32'(freq) * 32'd128;
		den = 32'd1000 << sh;
		q   = (num + (den >> 1)) / den;
		return q[7:0];
	endfunction

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				vcg_pkg::APB_CMD:    prdata <= {15'h0000, cmd};
				vcg_pkg::APB_STATUS: prdata <= {16'h0000, read_data, 7'h00, busy};
				vcg_pkg::APB_SAMPLE: prdata <= {16'h0000, sample_hold};
				vcg_pkg::APB_CONFIG: prdata <= {27'h0000000, config_bits};
				vcg_pkg::APB_TONES:  prdata <= {16'h0000, word_hi, word_lo};
				default:             prdata <= 32'h0000_0000;
			endcase
		end
	end

	// orders from software; a command or tones write while busy is dropped
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state       <= S_IDLE;
			cmd         <= 17'h00000;
			sample_hold <= 16'h0000;
			config_bits <= 5'h00;
			word_hi     <= 8'h00;
			word_lo     <= 8'h00;
		end else begin
			if (apb_wr && paddr == vcg_pkg::APB_SAMPLE)
				sample_hold <= pwdata[15:0];
			if (apb_wr && paddr == vcg_pkg::APB_CONFIG)
				config_bits <= pwdata[4:0];
			unique case (state)
				S_IDLE: begin
					if (apb_wr && paddr == vcg_pkg::APB_CMD) begin
						cmd   <= pwdata[16:0];
						state <= S_CMD;
					end else if (apb_wr && paddr == vcg_pkg::APB_TONES) begin
						// higher frequency always goes to the high register
						if (pwdata[23:12] >= pwdata[11:0]) begin
							word_hi <= tone_word(pwdata[23:12], tone_res);
							word_lo <= tone_word(pwdata[11:0], tone_res);
						end else begin
							word_hi <= tone_word(pwdata[11:0], tone_res);
							word_lo <= tone_word(pwdata[23:12], tone_res);
						end
						state <= S_HI;
					end
				end
				S_CMD:   if (link.reg_ack) state <= S_IDLE;
				S_HI:    if (link.reg_ack) state <= S_LO;
				S_LO:    if (link.reg_ack) state <= S_IDLE;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			issued         <= 1'b0;
			link.reg_wr    <= 1'b0;
			link.reg_rd    <= 1'b0;
			link.reg_addr  <= 8'h00;
			link.reg_wdata <= 8'h00;
			read_data      <= 8'h00;
		end else begin
			link.reg_wr <= 1'b0;
			link.reg_rd <= 1'b0;
			if (link.reg_ack) begin
				issued <= 1'b0;
				if (state == S_CMD && cmd[vcg_pkg::CMD_READ_BIT])
					read_data <= link.reg_rdata;
			end else if (busy && !issued) begin
				issued <= 1'b1;
				unique case (state)
					S_CMD: begin
						link.reg_rd    <= cmd[vcg_pkg::CMD_READ_BIT];
						link.reg_wr    <= !cmd[vcg_pkg::CMD_READ_BIT];
						link.reg_addr  <= cmd[15:8];
						link.reg_wdata <= cmd[7:0];
					end
					S_HI: begin
						link.reg_wr    <= 1'b1;
						link.reg_addr  <= vcg_pkg::ADDR_TONE_HI;
						link.reg_wdata <= word_hi;
					end
					default: begin
						link.reg_wr    <= 1'b1;
						link.reg_addr  <= vcg_pkg::ADDR_TONE_LO;
						link.reg_wdata <= word_lo;
					end
				endcase
			end
		end
	end

	// pcm framing: sync every 8 kHz with bit 1, sixteen strobes per frame
	logic [11:0] frame_cnt;
	logic [3:0]  bit_cnt;
	logic [4:0]  slot;
	logic [15:0] frame_word;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			frame_cnt              <= 12'h000;
			bit_cnt                <= 4'h0;
			slot                   <= 5'h00;
			frame_word             <= 16'h0000;
			link.sample_frame_sync <= 1'b0;
			link.bit_strobe        <= 1'b0;
			link.pcm_data          <= 1'b0;
		end else begin
			link.sample_frame_sync <= 1'b0;
			link.bit_strobe        <= 1'b0;
			frame_cnt <= (frame_cnt == 12'(vcg_pkg::FRAME_CYC - 1)) ? 12'h000 : frame_cnt + 12'h001;
			if (frame_cnt == 12'h000) begin
				// linear: 15 bits then empty slot 16; companded: 8 bits then gain bits
				frame_word <= config_bits[0] ? {sample_hold[14:0], 1'b0} :
					{sample_hold[7:0], config_bits[4:1], 4'h0};
				slot    <= 5'h01;
				bit_cnt <= 4'h0;
			end else if (slot != 5'h00) begin
				bit_cnt <= (bit_cnt == 4'(vcg_pkg::BIT_CYC - 1)) ? 4'h0 : bit_cnt + 4'h1;
				if (bit_cnt == 4'h0) begin
					link.bit_strobe        <= 1'b1;
					link.sample_frame_sync <= slot == 5'h01;
					link.pcm_data          <= frame_word[15];
					frame_word             <= {frame_word[14:0], 1'b0};
					slot <= (slot == vcg_pkg::SLOTS) ? 5'h00 : slot + 5'h01;
				end
			end
		end
	end
endmodule

/* verilog/vcg_link_if.sv */
// link between the codec control device and its host
`timescale 1ns/1ps
interface vcg_link_if;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       reg_ack;
	logic       sample_frame_sync;
	logic       bit_strobe;
	logic       pcm_data;
	modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, sample_frame_sync, bit_strobe,
		pcm_data, output reg_rdata, reg_ack);
	modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, sample_frame_sync, bit_strobe,
		pcm_data, input reg_rdata, reg_ack);
endinterface

/* verilog/vcg_pkg.sv */
// constants shared by the codec control ends
package vcg_pkg;
	// device register addresses
	localparam logic [7:0] ADDR_POWER    = 8'h00;
	localparam logic [7:0] ADDR_TX_GAIN  = 8'h01;
	localparam logic [7:0] ADDR_RX_GAIN  = 8'h02;
	localparam logic [7:0] ADDR_ST_VOL   = 8'h03;
	localparam logic [7:0] ADDR_TONE_HI  = 8'h04;
	localparam logic [7:0] ADDR_TONE_LO  = 8'h05;
	localparam logic [7:0] ADDR_AUX      = 8'h06;
	localparam int         NUM_REGS      = 7;
	// reset values
	localparam logic [7:0] RST_POWER     = 8'h00;
	localparam logic [7:0] RST_TX_GAIN   = 8'h0B;
	localparam logic [7:0] RST_RX_GAIN   = 8'h0A;
	localparam logic [7:0] RST_ST_VOL    = 8'h00;
	localparam logic [7:0] RST_TONE      = 8'h00;
	localparam logic [7:0] RST_AUX       = 8'h00;
	// field positions
	localparam int BIT_EAR_MUTE  = 3;
	localparam int BIT_MIC_MUTE  = 6;
	localparam int BIT_ST_MUTE   = 7;
	localparam int BIT_TONE_MODE = 0;
	localparam int BIT_LINEAR    = 1;
	localparam int RES_LSB       = 2;
	localparam int ST_LSB        = 4;
	// gain figures, transmit in half dB
	localparam logic [6:0] TX_EXT_TOP_X2  = 7'h53;
	localparam logic [6:0] TX_NORM_TOP_X2 = 7'h3B;
	localparam logic [3:0] TX_EXT_LAST    = 4'h5;
	localparam logic [3:0] TX_NORM_FIRST  = 4'h8;
	localparam logic [3:0] TX_NORM_LAST   = 4'hD;
	localparam logic [3:0] RX_LAST        = 4'hC;
	localparam logic [6:0] MIC_MUTE_DB    = 7'h50;
	localparam logic [3:0] TONE_HI_AMP    = 4'h5;
	localparam logic [3:0] TONE_LO_AMP    = 4'h4;
	// frame layout
	localparam logic [4:0] SLOTS          = 5'h10;
	localparam logic [4:0] COMP_BITS      = 5'h08;
	localparam logic [4:0] LIN_BITS       = 5'h0F;
	localparam logic [4:0] FGAIN_BITS     = 5'h04;
	// timing at 25 MHz
	localparam int CLK_NS        = 40;
	localparam int FRAME_NS      = 125000;
	localparam int BIT_NS        = 488;
	localparam int FRAME_CYC     = FRAME_NS / CLK_NS;
	localparam int BIT_CYC       = BIT_NS / CLK_NS;
	// host apb offsets
	localparam logic [7:0] APB_CMD    = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_SAMPLE = 8'h08;
	localparam logic [7:0] APB_CONFIG = 8'h0C;
	localparam logic [7:0] APB_TONES  = 8'h10;
	localparam int CMD_READ_BIT = 16;
	localparam int TONES_RES_LSB = 24;
endpackage
